// ==== inc/sfrb_defs.svh ====
`ifndef SFRB_DEFS_SVH
`define SFRB_DEFS_SVH
// Register offsets of the byte registers on the 16-bit register bus
`define SFRB_OFS_COMPAT_PSW 11'h402
`define SFRB_OFS_SEG_SELECT 11'h403
`define SFRB_OFS_T01_CTRL 11'h410
`define SFRB_OFS_T01_EXT_STATUS 11'h411
`define SFRB_OFS_T2_CTRL 11'h418
`define SFRB_OFS_T2_MODE 11'h419
`define SFRB_OFS_WDOG_CTRL 11'h41f
`define SFRB_OFS_SOFT_IRQ_REQ 11'h42a
`define SFRB_OFS_SYS_CONFIG 11'h440
`define SFRB_OFS_T0_CNT_LO 11'h450
`define SFRB_OFS_T0_CNT_HI 11'h451
`define SFRB_OFS_T1_CNT_LO 11'h452
`define SFRB_OFS_T1_CNT_HI 11'h453
`define SFRB_OFS_T2_CNT_LO 11'h458
`define SFRB_OFS_T2_CNT_HI 11'h459
`define SFRB_OFS_T2_SNAP_LO 11'h45a
`define SFRB_OFS_T2_SNAP_HI 11'h45b
`define SFRB_OFS_T01_MODE 11'h45c
`define SFRB_OFS_WDOG_FEED1 11'h45d
`define SFRB_OFS_WDOG_FEED2 11'h45e
`define SFRB_OFS_WDOG_RELOAD 11'h45f
`define SFRB_OFS_RESET_CAUSE 11'h463
`define SFRB_OFS_UART1_MASK 11'h466
`define SFRB_OFS_BUS_CONFIG 11'h46a
`define SFRB_OFS_PORT_CFG_A 11'h470
`define SFRB_OFS_SOFT_IRQ_EN 11'h47a
`define SFRB_OFS_PORT_CFG_B 11'h4f0
// Implemented-bit masks; other bits store nothing and read zero
`define SFRB_MASK_T01_EXT_STATUS 8'h05
`define SFRB_MASK_T2_MODE 8'h33
`define SFRB_MASK_WDOG_CTRL 8'he6
`define SFRB_MASK_SOFT_IRQ 8'h7f
`define SFRB_MASK_SYS_CONFIG 8'h0f
`define SFRB_MASK_RESET_CAUSE 8'h07
`define SFRB_MASK_BUS_CONFIG 8'h07
// Bit positions
`define SFRB_BIT_WDTOF 1
`define SFRB_BIT_BUS_WIDTH 2
`define SFRB_BIT_CAUSE_WD 2
`define SFRB_BIT_CAUSE_CMD 1
`define SFRB_BIT_CAUSE_EXT 0
// Reset values
`define SFRB_RST_WDOG_OTHER 8'he4
`define SFRB_RST_WDOG_WD 8'he6
`define SFRB_RST_BUS_CONFIG 8'h03
`define SFRB_RST_CFG_A 8'hff
`define SFRB_RST_CFG_B 8'h00
`define SFRB_RST_PSW_CLEAR 8'h23
`define SFRB_RST_ZERO 8'h00
`define SFRB_SYNC_CYCLES 2'h2
`endif

// ==== inc/sfrb_pkg.sv ====
package sfrb_pkg;
  // One register byte and one register address
  typedef logic [7:0] sfrb_byte_t;
  typedef logic [10:0] sfrb_addr_t;
  typedef logic [4:0] sfrb_mem_idx_t;
  // Start-up sequencer
  typedef enum logic [1:0]
  {
    SFRB_ST_SYNC = 2'b00,
    SFRB_ST_LOAD = 2'b01,
    SFRB_ST_RUN = 2'b10
  } sfrb_state_t;
endpackage

// ==== inc/sfrb_mem_if.sv ====
`timescale 1ns/1ps
interface sfrb_mem_if;
  import sfrb_pkg::*;
  logic wr_en;
  logic rd_en;
  sfrb_mem_idx_t idx;
  sfrb_byte_t wdata;
  sfrb_byte_t rdata;
  // Bank side issues, memory side answers one cycle later
  modport bank (output wr_en, output rd_en, output idx, output wdata, input rdata);
  modport mem (input wr_en, input rd_en, input idx, input wdata, output rdata);
endinterface

// ==== rtl/sfrb_byte_mem.sv ====
`timescale 1ns/1ps
`include "sfrb_defs.svh"
module sfrb_byte_mem #(
  parameter int DEPTH = 32
) (
  input wire logic i_clk,
  input wire logic i_rst,
  sfrb_mem_if.mem mem
);
  import sfrb_pkg::*;

  // Storage for the plain read/write bytes
  sfrb_byte_t store_q [DEPTH];
  // Registered read data
  sfrb_byte_t rdata_q;

  // Write port; every byte resets to zero
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      for (int k = 0; k < DEPTH; k++)
        store_q[k] <= `SFRB_RST_ZERO;
    end
    else if (mem.wr_en)
    begin
      store_q[mem.idx] <= mem.wdata;
    end
  end

  // Read port, data one cycle after the strobe
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      rdata_q <= `SFRB_RST_ZERO;
    else if (mem.rd_en)
      rdata_q <= store_q[mem.idx];
  end

  assign mem.rdata = rdata_q;
endmodule

// ==== rtl/sfrb_bank.sv ====
`timescale 1ns/1ps
`include "sfrb_defs.svh"
module sfrb_bank #(
  parameter int NUM_PORTS = 7,
  parameter logic [8*NUM_PORTS-1:0] EXT_BUS_PUSH_PULL = 56'h00_00_00_00_ff_00_ff
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire sfrb_pkg::sfrb_addr_t i_sfr_addr,
  input wire logic i_sfr_rd,
  input wire logic i_sfr_wr,
  input wire logic i_sfr_word,
  input wire logic i_sfr_rmw,
  input wire logic [15:0] i_sfr_wdata,
  output logic [15:0] o_sfr_rdata,
  output logic o_sfr_rvalid,
  output logic o_sfr_ready,
  input wire logic i_bus_width_pin,
  input wire logic i_external_code_select_pin,
  input wire sfrb_pkg::sfrb_byte_t i_reset_psw,
  input wire logic i_wd_reset_cause,
  input wire logic i_cmd_reset_cause,
  input wire logic [5:0] i_flag_set,
  output sfrb_pkg::sfrb_byte_t o_timer01_control,
  output sfrb_pkg::sfrb_byte_t o_timer2_control,
  output sfrb_pkg::sfrb_byte_t o_watchdog_control,
  output sfrb_pkg::sfrb_byte_t o_bus_config_reg,
  output sfrb_pkg::sfrb_byte_t o_reset_cause_reg,
  output sfrb_pkg::sfrb_byte_t o_compat_status_word,
  output logic [8*NUM_PORTS-1:0] o_port_config_a,
  output logic [8*NUM_PORTS-1:0] o_port_config_b,
  output logic o_feed_first,
  output logic o_feed_second
);
  import sfrb_pkg::*;

  // Guarded flags: timer01 control bits 7,5,3,1, timer2 bit 7, watchdog bit 1
  localparam int NUM_GUARD = 6;

  sfrb_mem_if mif ();

  // Pin synchronisers; first stage read only by the second
  logic [1:0] width_sync_q;
  logic [1:0] ext_sync_q;
  // Sequencer state
  sfrb_state_t state_q;
  logic [1:0] sync_cnt_q;
  // Registers held in flops
  sfrb_byte_t t01_ctrl_q;
  sfrb_byte_t t2_ctrl_q;
  sfrb_byte_t wdog_ctrl_q;
  sfrb_byte_t bus_cfg_q;
  sfrb_byte_t cause_q;
  sfrb_byte_t psw_q;
  sfrb_byte_t cfg_a_q [NUM_PORTS];
  sfrb_byte_t cfg_b_q [NUM_PORTS];
  // Set since last read or write of its register, per guarded flag
  logic [NUM_GUARD-1:0] track_q;
  logic [NUM_GUARD-1:0] guard_cur;
  logic [NUM_GUARD-1:0] guard_hit;
  logic [NUM_GUARD-1:0] guard_d;
  // Read pipeline
  logic rd_p1_q;
  logic rd_mem_q;
  sfrb_byte_t rd_local_q;
  // Access decode
  logic run;
  logic wr_fire;
  logic rd_fire;
  sfrb_byte_t wbyte;
  sfrb_byte_t local_byte;
  logic mem_hit;
  sfrb_mem_idx_t mem_idx;

  // Accesses are taken only once the start-up loads are done
  assign run = (state_q == SFRB_ST_RUN);
  assign wr_fire = i_sfr_wr & run;
  assign rd_fire = i_sfr_rd & run & ~i_sfr_wr;
  // Only the low byte of a word write reaches any register
  assign wbyte = i_sfr_wdata[7:0];

  // Map of plain bytes held in the memory module
  always_comb
  begin
    mem_hit = 1'b1;
    mem_idx = 5'h00;
    case (i_sfr_addr)
      `SFRB_OFS_SEG_SELECT: mem_idx = 5'h00;
      `SFRB_OFS_T01_EXT_STATUS: mem_idx = 5'h01;
      `SFRB_OFS_T2_MODE: mem_idx = 5'h02;
      `SFRB_OFS_SOFT_IRQ_REQ: mem_idx = 5'h03;
      `SFRB_OFS_SYS_CONFIG: mem_idx = 5'h04;
      `SFRB_OFS_T0_CNT_LO: mem_idx = 5'h05;
      `SFRB_OFS_T0_CNT_HI: mem_idx = 5'h06;
      `SFRB_OFS_T1_CNT_LO: mem_idx = 5'h07;
      `SFRB_OFS_T1_CNT_HI: mem_idx = 5'h08;
      `SFRB_OFS_T2_CNT_LO: mem_idx = 5'h09;
      `SFRB_OFS_T2_CNT_HI: mem_idx = 5'h0a;
      `SFRB_OFS_T2_SNAP_LO: mem_idx = 5'h0b;
      `SFRB_OFS_T2_SNAP_HI: mem_idx = 5'h0c;
      `SFRB_OFS_T01_MODE: mem_idx = 5'h0d;
      `SFRB_OFS_WDOG_RELOAD: mem_idx = 5'h0e;
      `SFRB_OFS_UART1_MASK: mem_idx = 5'h0f;
      `SFRB_OFS_SOFT_IRQ_EN: mem_idx = 5'h10;
      default: mem_hit = 1'b0;
    endcase
  end

  // Narrow bytes are masked on the way in, so unused bits stay zero
  function automatic sfrb_byte_t mem_mask(input sfrb_addr_t a);
    case (a)
      `SFRB_OFS_T01_EXT_STATUS: mem_mask = `SFRB_MASK_T01_EXT_STATUS;
      `SFRB_OFS_T2_MODE: mem_mask = `SFRB_MASK_T2_MODE;
      `SFRB_OFS_SOFT_IRQ_REQ: mem_mask = `SFRB_MASK_SOFT_IRQ;
      `SFRB_OFS_SOFT_IRQ_EN: mem_mask = `SFRB_MASK_SOFT_IRQ;
      `SFRB_OFS_SYS_CONFIG: mem_mask = `SFRB_MASK_SYS_CONFIG;
      default: mem_mask = 8'hff;
    endcase
  endfunction

  assign mif.wr_en = wr_fire & mem_hit;
  assign mif.rd_en = rd_fire & mem_hit;
  assign mif.idx = mem_idx;
  assign mif.wdata = wbyte & mem_mask(i_sfr_addr);

  sfrb_byte_mem #(
    .DEPTH(32)
  ) sfrb_byte_mem_inst (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .mem(mif.mem)
  );

  // Flop-held registers for the read mux
  always_comb
  begin
    local_byte = `SFRB_RST_ZERO;
    case (i_sfr_addr)
      `SFRB_OFS_COMPAT_PSW: local_byte = psw_q;
      `SFRB_OFS_T01_CTRL: local_byte = t01_ctrl_q;
      `SFRB_OFS_T2_CTRL: local_byte = t2_ctrl_q;
      `SFRB_OFS_WDOG_CTRL: local_byte = wdog_ctrl_q;
      `SFRB_OFS_RESET_CAUSE: local_byte = cause_q;
      `SFRB_OFS_BUS_CONFIG: local_byte = bus_cfg_q;
      default:
      begin
        // Port configuration banks, feed bytes read as zero
        for (int p = 0; p < NUM_PORTS; p++)
        begin
          if (i_sfr_addr == `SFRB_OFS_PORT_CFG_A + 11'(p))
            local_byte = cfg_a_q[p];
          if (i_sfr_addr == `SFRB_OFS_PORT_CFG_B + 11'(p))
            local_byte = cfg_b_q[p];
        end
      end
    endcase
  end

  // Two-flop synchronisers for the strap pins
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      width_sync_q <= 2'h0;
      ext_sync_q <= 2'h0;
    end
    else
    begin
      width_sync_q <= {width_sync_q[0], i_bus_width_pin};
      ext_sync_q <= {ext_sync_q[0], i_external_code_select_pin};
    end
  end

  // Start-up: let the straps settle, load once, then serve the bus
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      state_q <= SFRB_ST_SYNC;
      sync_cnt_q <= 2'h0;
    end
    else
    begin
      case (state_q)
        SFRB_ST_SYNC:
        begin
          sync_cnt_q <= sync_cnt_q + 2'h1;
          if (sync_cnt_q == `SFRB_SYNC_CYCLES - 2'h1)
            state_q <= SFRB_ST_LOAD;
        end
        SFRB_ST_LOAD: state_q <= SFRB_ST_RUN;
        SFRB_ST_RUN: state_q <= SFRB_ST_RUN;
        default: state_q <= SFRB_ST_SYNC;
      endcase
    end
  end

  // Ready flag straight from a flop for the core
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      o_sfr_ready <= 1'b0;
    else
      o_sfr_ready <= (state_q == SFRB_ST_LOAD) | run;
  end

  // Current values of the guarded flags
  assign guard_cur = {wdog_ctrl_q[`SFRB_BIT_WDTOF], t2_ctrl_q[7], t01_ctrl_q[1],
                      t01_ctrl_q[3], t01_ctrl_q[5], t01_ctrl_q[7]};

  // Per guarded flag: peripheral set wins except at the watchdog flag in the load cycle; a read-modify-write
  // write-back cannot clear a flag set after the read that fed it
  for (genvar g = 0; g < NUM_GUARD; g++)
  begin : g_guard
    localparam sfrb_addr_t GA = (g < 4) ? `SFRB_OFS_T01_CTRL :
                                (g == 4) ? `SFRB_OFS_T2_CTRL : `SFRB_OFS_WDOG_CTRL;
    localparam int GB = (g < 4) ? 7 - 2 * g : (g == 4) ? 7 : `SFRB_BIT_WDTOF;
    assign guard_hit[g] = wr_fire & (i_sfr_addr == GA);
    assign guard_d[g] = i_flag_set[g] | (guard_hit[g] ?
                        (wbyte[GB] | (i_sfr_rmw & track_q[g])) : guard_cur[g]);

    always_ff @(posedge i_clk or posedge i_rst)
    begin
      if (i_rst)
        track_q[g] <= 1'b0;
      else
        track_q[g] <= i_flag_set[g] |
                      (track_q[g] & ~guard_hit[g] & ~(rd_fire & (i_sfr_addr == GA)));
    end
  end

  // Timer control registers, plain bits plus guarded flags
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      t01_ctrl_q <= `SFRB_RST_ZERO;
      t2_ctrl_q <= `SFRB_RST_ZERO;
    end
    else
    begin
      if (wr_fire && i_sfr_addr == `SFRB_OFS_T01_CTRL)
        t01_ctrl_q <= {guard_d[0], wbyte[6], guard_d[1], wbyte[4],
                       guard_d[2], wbyte[2], guard_d[3], wbyte[0]};
      else
        t01_ctrl_q <= {guard_d[0], t01_ctrl_q[6], guard_d[1], t01_ctrl_q[4],
                       guard_d[2], t01_ctrl_q[2], guard_d[3], t01_ctrl_q[0]};
      if (wr_fire && i_sfr_addr == `SFRB_OFS_T2_CTRL)
        t2_ctrl_q <= {guard_d[4], wbyte[6:0]};
      else
        t2_ctrl_q <= {guard_d[4], t2_ctrl_q[6:0]};
    end
  end

  // Watchdog control; its reset value depends on the reset cause
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      wdog_ctrl_q <= `SFRB_RST_WDOG_OTHER;
    else if (state_q == SFRB_ST_LOAD)
      wdog_ctrl_q <= i_wd_reset_cause ? `SFRB_RST_WDOG_WD : `SFRB_RST_WDOG_OTHER;
    else if (wr_fire && i_sfr_addr == `SFRB_OFS_WDOG_CTRL)
    begin
      wdog_ctrl_q <= (wbyte & `SFRB_MASK_WDOG_CTRL & ~8'h02) | {6'h00, guard_d[5], 1'b0};
    end
    else
    begin
      wdog_ctrl_q[`SFRB_BIT_WDTOF] <= guard_d[5];
    end
  end

  // Reset cause: one-hot, watchdog before command before pin
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      cause_q <= `SFRB_RST_ZERO;
    else if (state_q == SFRB_ST_LOAD)
    begin
      cause_q <= `SFRB_RST_ZERO;
      if (i_wd_reset_cause)
        cause_q[`SFRB_BIT_CAUSE_WD] <= 1'b1;
      else if (i_cmd_reset_cause)
        cause_q[`SFRB_BIT_CAUSE_CMD] <= 1'b1;
      else
        cause_q[`SFRB_BIT_CAUSE_EXT] <= 1'b1;
    end
  end

  // Bus configuration: strap caught after release, writable afterwards
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      bus_cfg_q <= `SFRB_RST_BUS_CONFIG;
    else if (state_q == SFRB_ST_LOAD)
      bus_cfg_q <= `SFRB_RST_BUS_CONFIG | {5'h00, width_sync_q[1], 2'h0};
    else if (wr_fire && i_sfr_addr == `SFRB_OFS_BUS_CONFIG)
      bus_cfg_q <= wbyte & `SFRB_MASK_BUS_CONFIG;
  end

  // Compatible status word, taken from the reset vector with flags cleared
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      psw_q <= `SFRB_RST_ZERO;
    else if (state_q == SFRB_ST_LOAD)
      psw_q <= i_reset_psw & ~`SFRB_RST_PSW_CLEAR;
    else if (wr_fire && i_sfr_addr == `SFRB_OFS_COMPAT_PSW)
      psw_q <= wbyte;
  end

  // Port configuration pairs, one per port
  for (genvar p = 0; p < NUM_PORTS; p++)
  begin : g_port
    always_ff @(posedge i_clk or posedge i_rst)
    begin
      if (i_rst)
      begin
        cfg_a_q[p] <= `SFRB_RST_CFG_A;
        cfg_b_q[p] <= `SFRB_RST_CFG_B;
      end
      else if (state_q == SFRB_ST_LOAD)
      begin
        cfg_a_q[p] <= `SFRB_RST_CFG_A;
        cfg_b_q[p] <= ext_sync_q[1] ? EXT_BUS_PUSH_PULL[8*p +: 8] : `SFRB_RST_CFG_B;
      end
      else if (wr_fire)
      begin
        if (i_sfr_addr == `SFRB_OFS_PORT_CFG_A + 11'(p))
          cfg_a_q[p] <= wbyte;
        if (i_sfr_addr == `SFRB_OFS_PORT_CFG_B + 11'(p))
          cfg_b_q[p] <= wbyte;
      end
    end
    assign o_port_config_a[8*p +: 8] = cfg_a_q[p];
    assign o_port_config_b[8*p +: 8] = cfg_b_q[p];
  end

  // Feed bytes only pulse toward the watchdog; nothing is stored
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_feed_first <= 1'b0;
      o_feed_second <= 1'b0;
    end
    else
    begin
      o_feed_first <= wr_fire & (i_sfr_addr == `SFRB_OFS_WDOG_FEED1);
      o_feed_second <= wr_fire & (i_sfr_addr == `SFRB_OFS_WDOG_FEED2);
    end
  end

  // Read pipeline: decode in cycle 0, memory answers in 1, output in 2.
  // Upper byte is driven zero; the core must not rely on it.
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      rd_p1_q <= 1'b0;
      rd_mem_q <= 1'b0;
      rd_local_q <= `SFRB_RST_ZERO;
      o_sfr_rvalid <= 1'b0;
      o_sfr_rdata <= 16'h0000;
    end
    else
    begin
      rd_p1_q <= rd_fire;
      rd_mem_q <= rd_fire & mem_hit;
      rd_local_q <= local_byte;
      o_sfr_rvalid <= rd_p1_q;
      o_sfr_rdata <= {8'h00, rd_mem_q ? mif.rdata : rd_local_q};
    end
  end

  assign o_timer01_control = t01_ctrl_q;
  assign o_timer2_control = t2_ctrl_q;
  assign o_watchdog_control = wdog_ctrl_q;
  assign o_bus_config_reg = bus_cfg_q;
  assign o_reset_cause_reg = cause_q;
  assign o_compat_status_word = psw_q;

  // Checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  chk_word_write_low: assert property (
    wr_fire && i_sfr_word && i_sfr_addr == `SFRB_OFS_BUS_CONFIG
    |=> bus_cfg_q == ($past(i_sfr_wdata[7:0]) & `SFRB_MASK_BUS_CONFIG))
    else $error("word write did not land in low byte");
  chk_read_timing: assert property (
    rd_fire |=> ##1 (o_sfr_rvalid && o_sfr_rdata[15:8] == 8'h00))
    else $error("read answer not two cycles later");
  chk_rmw_guard: assert property (
    guard_hit[5] && i_sfr_rmw && track_q[5] |=> wdog_ctrl_q[`SFRB_BIT_WDTOF])
    else $error("write-back cleared a fresh flag");
  chk_flag_set_wins: assert property (
    i_flag_set[0] && run |=> t01_ctrl_q[7])
    else $error("flag set was lost");
  chk_wdog_reset_value: assert property (
    state_q == SFRB_ST_LOAD |=> o_watchdog_control ==
    ($past(i_wd_reset_cause) ? `SFRB_RST_WDOG_WD : `SFRB_RST_WDOG_OTHER))
    else $error("watchdog control reset value wrong");
  chk_cause_onehot: assert property (
    run |-> $onehot(cause_q))
    else $error("reset cause not one-hot");
  chk_bus_cfg_strap: assert property (
    state_q == SFRB_ST_LOAD |=> bus_cfg_q == {5'h00, $past(width_sync_q[1]), 2'h3})
    else $error("bus config reset value wrong");
  chk_port_internal: assert property (
    state_q == SFRB_ST_LOAD && !ext_sync_q[1]
    |=> o_port_config_a == {NUM_PORTS{8'hff}} && o_port_config_b == '0)
    else $error("ports not quasi-bidirectional");
  chk_port_external: assert property (
    state_q == SFRB_ST_LOAD && ext_sync_q[1] |=> o_port_config_b == EXT_BUS_PUSH_PULL)
    else $error("bus pins not push-pull");
  chk_unimpl_zero: assert property (
    (bus_cfg_q & ~`SFRB_MASK_BUS_CONFIG) == 8'h00 && (cause_q & ~`SFRB_MASK_RESET_CAUSE) == 8'h00)
    else $error("unimplemented bits set");
  chk_psw_flags_clear: assert property (
    state_q == SFRB_ST_LOAD |=> (psw_q & `SFRB_RST_PSW_CLEAR) == 8'h00)
    else $error("status word flags not cleared");
  chk_unmapped_write: assert property (
    wr_fire && i_sfr_addr == 11'h7ff |=> $stable(bus_cfg_q) && $stable(psw_q))
    else $error("unmapped write changed a register");

  cov_rmw_guard: cover property (guard_hit[0] && i_sfr_rmw && track_q[0]);
  cov_wd_start: cover property (state_q == SFRB_ST_LOAD && i_wd_reset_cause);
  cov_ext_start: cover property (state_q == SFRB_ST_LOAD && ext_sync_q[1]);
  cov_mem_read: cover property (rd_fire && mem_hit ##2 o_sfr_rvalid);
endmodule

// ==== tb/sfrb_core_model.sv ====
`timescale 1ns/1ps
module sfrb_core_model (
  input wire logic i_clk,
  output sfrb_pkg::sfrb_addr_t o_addr,
  output logic o_rd,
  output logic o_wr,
  output logic o_word,
  output logic o_rmw,
  output logic [15:0] o_wdata
);
  import sfrb_pkg::*;

  // Idle bus at time zero
  initial
  begin
    o_addr = '0;
    o_rd = 1'b0;
    o_wr = 1'b0;
    o_word = 1'b0;
    o_rmw = 1'b0;
    o_wdata = '0;
  end

  // One transfer, held through the taking edge and until the next call or idle,
  // so back-to-back calls never drop and raise a strobe in one step
  task automatic xfer(input sfrb_addr_t a, input logic w, input logic [15:0] d,
                      input logic wd, input logic m);
  begin
    o_addr = a;
    o_wr = w;
    o_rd = !w;
    o_wdata = d;
    o_word = wd;
    o_rmw = m;
    @(posedge i_clk);
    #1;
  end
  endtask

  // Release the bus; released lines show the inverse, so a stale value is never new
  task automatic idle();
  begin
    o_rd = 1'b0;
    o_wr = 1'b0;
    o_rmw = 1'b0;
    o_addr = ~o_addr;
    o_wdata = ~o_wdata;
  end
  endtask
endmodule

// ==== tb/test_sfr_bank_bus_and_reset.sv ====
`timescale 1ns/1ps
module test_sfr_bank_bus_and_reset;
  import sfrb_pkg::*;
  // Ports 0 and 2 carry the external bus in this build
  localparam logic [55:0] EXT_PP = 56'h00_00_00_00_ff_00_ff;
  logic i_clk, i_rst, i_bus_width_pin, i_external_code_select_pin;
  logic i_wd_reset_cause, i_cmd_reset_cause;
  logic [5:0] i_flag_set;
  sfrb_byte_t i_reset_psw;
  sfrb_addr_t i_sfr_addr;
  logic i_sfr_rd, i_sfr_wr, i_sfr_word, i_sfr_rmw;
  logic [15:0] i_sfr_wdata, o_sfr_rdata;
  logic o_sfr_rvalid, o_sfr_ready, o_feed_first, o_feed_second;
  sfrb_byte_t o_t01, o_t2, o_wdog, o_bus, o_cause, o_psw;
  logic [55:0] o_cfg_a, o_cfg_b;
  int fails = 0;
  int checks = 0;
  int seed = 3241;
  int cycles = 0;
  sfrb_byte_t exp_q[$];
  // Read/write registers and the bits that hold state
  sfrb_addr_t offs[14] = '{11'h403, 11'h411, 11'h419, 11'h42a, 11'h440, 11'h450, 11'h451,
    11'h452, 11'h453, 11'h458, 11'h45b, 11'h45c, 11'h45f, 11'h466};
  sfrb_byte_t masks[14] = '{8'hff, 8'h05, 8'h33, 8'h7f, 8'h0f, 8'hff, 8'hff, 8'hff, 8'hff,
    8'hff, 8'hff, 8'hff, 8'hff, 8'hff};
  sfrb_byte_t vals[14];

  sfrb_bank #(.NUM_PORTS(7), .EXT_BUS_PUSH_PULL(EXT_PP)) sfrb_bank_inst (.i_clk(i_clk),
    .i_rst(i_rst), .i_sfr_addr(i_sfr_addr), .i_sfr_rd(i_sfr_rd), .i_sfr_wr(i_sfr_wr),
    .i_sfr_word(i_sfr_word), .i_sfr_rmw(i_sfr_rmw), .i_sfr_wdata(i_sfr_wdata),
    .o_sfr_rdata(o_sfr_rdata), .o_sfr_rvalid(o_sfr_rvalid), .o_sfr_ready(o_sfr_ready),
    .i_bus_width_pin(i_bus_width_pin), .i_external_code_select_pin(i_external_code_select_pin),
    .i_reset_psw(i_reset_psw), .i_wd_reset_cause(i_wd_reset_cause),
    .i_cmd_reset_cause(i_cmd_reset_cause), .i_flag_set(i_flag_set),
    .o_timer01_control(o_t01), .o_timer2_control(o_t2), .o_watchdog_control(o_wdog),
    .o_bus_config_reg(o_bus), .o_reset_cause_reg(o_cause), .o_compat_status_word(o_psw),
    .o_port_config_a(o_cfg_a), .o_port_config_b(o_cfg_b), .o_feed_first(o_feed_first),
    .o_feed_second(o_feed_second));

  sfrb_core_model sfrb_core_model_inst (.i_clk(i_clk), .o_addr(i_sfr_addr), .o_rd(i_sfr_rd),
    .o_wr(i_sfr_wr), .o_word(i_sfr_word), .o_rmw(i_sfr_rmw), .o_wdata(i_sfr_wdata));

  // Free-running system clock
  initial
  begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end

  // Register values, up to a whole port configuration vector
  task automatic cmp_reg(input string name, input logic [63:0] exp, input logic [63:0] got);
  begin
    checks++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  end
  endtask

  // Single flags and strobes
  task automatic cmp_bit(input string name, input logic exp, input logic got);
  begin
    checks++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  end
  endtask

  // Read answers against the oldest note
  task automatic cmp_read(input sfrb_byte_t exp, input sfrb_byte_t got);
  begin
    checks++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED read data expected %h seen %h", exp, got);
    end
  end
  endtask

  task automatic complete_run();
  begin
    if (fails == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  end
  endtask

  // Word write with random upper byte; only the low byte may land
  task automatic wr(input sfrb_addr_t a, input sfrb_byte_t d, input logic m);
    logic [7:0] hi;
  begin
    hi = 8'($random(seed));
    sfrb_core_model_inst.xfer(a, 1'b1, {hi, d}, 1'b1, m);
  end
  endtask

  // Read with its expected byte noted for the watcher
  task automatic rd(input sfrb_addr_t a, input sfrb_byte_t e);
  begin
    exp_q.push_back(e);
    sfrb_core_model_inst.xfer(a, 1'b0, 16'h0000, 1'b1, 1'b0);
  end
  endtask

  // Reset with straps and cause held stable until the bank is ready
  task automatic do_reset(input logic wd, input logic cmd, input logic ext, input logic bw);
    int n;
  begin
    i_wd_reset_cause = wd;
    i_cmd_reset_cause = cmd;
    i_external_code_select_pin = ext;
    i_bus_width_pin = bw;
    i_reset_psw = 8'($random(seed));
    i_rst = 1'b1;
    repeat (3) @(posedge i_clk);
    #1;
    i_rst = 1'b0;
    n = 0;
    while (o_sfr_ready !== 1'b1 && n < 20)
    begin
      @(posedge i_clk);
      #1;
      n++;
    end
    cmp_reg("watchdog control", wd ? 8'he6 : 8'he4, o_wdog);
    cmp_reg("reset cause", wd ? 8'h04 : (cmd ? 8'h02 : 8'h01), o_cause);
    cmp_reg("bus config", {5'b00000, bw, 2'b11}, o_bus);
    cmp_reg("port config a", {56{1'b1}}, o_cfg_a);
    cmp_reg("port config b", ext ? EXT_PP : 56'h0, o_cfg_b);
    cmp_reg("status word", i_reset_psw & 8'hdc, o_psw);
  end
  endtask

  // Watcher: each read answer takes the oldest note
  always @(posedge i_clk)
    if (o_sfr_rvalid === 1'b1)
      cmp_read(exp_q.size() ? exp_q.pop_front() : 8'hxx, o_sfr_rdata[7:0]);

  // Hang guard
  always @(posedge i_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      fails++;
      complete_run();
    end
  end

  initial
  begin
    i_flag_set = 6'h00;
    do_reset(1'b1, 1'b0, 1'b1, 1'b0);
    do_reset(1'b0, 1'b1, 1'b0, 1'b1);
    do_reset(1'b0, 1'b0, 1'b0, 1'b1);
    // Back-to-back writes, then pipelined reads of the same places
    for (int i = 0; i < 14; i++)
    begin
      vals[i] = 8'($random(seed)) & masks[i];
      wr(offs[i], vals[i], 1'b0);
    end
    wr(11'h46a, 8'h05, 1'b0);
    wr(11'h454, 8'haa, 1'b0);
    wr(11'h7ff, 8'h5a, 1'b0);
    for (int i = 0; i < 14; i++)
      rd(offs[i], vals[i]);
    rd(11'h46a, 8'h05);
    rd(11'h454, 8'h00);
    rd(11'h7ff, 8'h00);
    // Feed strobes pulse the cycle after their write
    wr(11'h45d, 8'ha5, 1'b0);
    cmp_bit("feed first", 1'b1, o_feed_first);
    wr(11'h45e, 8'h5a, 1'b0);
    cmp_bit("feed second", 1'b1, o_feed_second);
    // Flag set between the read and the write-back of a read-modify-write
    wr(11'h410, 8'h00, 1'b0);
    rd(11'h410, 8'h00);
    sfrb_core_model_inst.idle();
    i_flag_set = 6'h31;
    @(posedge i_clk);
    #1;
    i_flag_set = 6'h00;
    wr(11'h410, 8'h00, 1'b1);
    cmp_bit("timer flag kept", 1'b1, o_t01[7]);
    cmp_bit("watchdog flag set", 1'b1, o_wdog[1]);
    cmp_bit("timer2 flag set", 1'b1, o_t2[7]);
    wr(11'h41f, 8'he4, 1'b1);
    cmp_reg("watchdog flag kept", 8'he6, o_wdog);
    wr(11'h41f, 8'he4, 1'b0);
    cmp_reg("watchdog flag cleared", 8'he4, o_wdog);
    wr(11'h410, 8'h00, 1'b0);
    cmp_bit("timer flag cleared", 1'b0, o_t01[7]);
    sfrb_core_model_inst.idle();
    repeat (4) @(posedge i_clk);
    #1;
    cmp_reg("reads outstanding", 64'h0, 64'(exp_q.size()));
    complete_run();
  end
endmodule
